// >>> include/gate_drv_map.svh
// Constants, offsets and timing counts of the gate driver protection logic
//
// Notes on behaviour
// - Desaturation comparator above its 5 V threshold against the source reference means fault.
// - Desaturation sense is discharged while inputs float or the gate is held low.
// - Desaturation detection only runs while the driver is in its on state.
// - After each gate rise, wait 200 ns blanking before enabling the 500 uA charge.
// - A detected fault turns the gate off through the reduced 400 mA soft sink.
// - A fault pulls the open-drain alarm low and latches it until a valid reset.
// - Reset requests are ignored during the mute interval after a fault latches.
// - Reset/enable defaults to disabled; it must be driven high to enable.
// - Low longer than the filter time after mute, then rising edge clears the alarm.
// - Reset/enable low longer than the filter time disables the driver, gate pulled low.
// - While off, the Miller clamp engages once the gate is below its 2 V threshold.
// - Sense duty rises linearly from 10% at 4.5 V to 88% at 0.6 V.
// - A floating sense input reads high and gives about 10% duty at 400 kHz.
// - The duty encoding stays within a 3% accuracy band without calibration.
// - Gate high only for noninverting high, inverting low, enabled; else low.
// - Gate stays low while either supply is in undervoltage lockout.
// - In lockout the supply-good output is pulled low and the sense output held low.
// - Both PWM inputs and reset/enable are deglitched; pulses under 40 ns vanish.
// - Both PWM inputs high together force the gate low.
`ifndef GATE_DRV_MAP_SVH
`define GATE_DRV_MAP_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define DEGLITCH_NS     40
`define DEGLITCH_CYC    ((`DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_NS        200
`define BLANK_CYC       ((`BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SENSED_DUTY_OUT_FREQ_KHZ   400
`define SENSED_DUTY_OUT_PERIOD_CYC (1000000 / (`SENSED_DUTY_OUT_FREQ_KHZ * `CLK_PERIOD_NS))
`define FAULT_MUTE_DEF  100
`define RST_FILTER_DEF  100

// ----------------------------------------------------------------
// Sense encoding
// ----------------------------------------------------------------
`define DUTY_MIN_PCT    10
`define DUTY_MAX_PCT    88
`define DUTY_MIN_CYC    (`SENSED_DUTY_OUT_PERIOD_CYC * `DUTY_MIN_PCT / 100)
`define DUTY_MAX_CYC    (`SENSED_DUTY_OUT_PERIOD_CYC * `DUTY_MAX_PCT / 100)
`define AIN_LO_MV       600
`define AIN_HI_MV       4500
`define AIN_MV_PER_CYC  ((`AIN_HI_MV - `AIN_LO_MV) / (`DUTY_MAX_CYC - `DUTY_MIN_CYC))

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define REG_STATUS      12'h000
`define REG_CONTROL     12'h004
`define REG_SENSE       12'h008
`define REG_FAULTS      12'h00C
`define CTRL_ALLOW_RST  1'b1
`define ERR_DATA        32'h00000000

`endif

// >>> include/gate_drv_pkg.sv
// Types shared by the gate driver protection logic
package gate_drv_pkg;

   typedef enum logic [2:0] {
      S_OFF  = 3'b001,
      S_ON   = 3'b010,
      S_SOFT = 3'b100
   } drv_state_t;

   typedef struct packed {
      logic clear_ready;
      logic enabled;
      logic uvlo;
      logic soft_off;
      logic gate_on;
      logic fault;
   } status_t;

endpackage

// >>> rtl/deglitch_bank.sv
// Input deglitch filters for the PWM and reset/enable pins
`timescale 1ns/1ps
`default_nettype none
`include "gate_drv_map.svh"

module deglitch_bank
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [2:0] raw,
   output var  logic [2:0] filt
);

   // ----------------------------------------------------------------
   // One filter per pin
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1)
      begin : g_pin
         logic [7:0] cnt;

         // Level must differ for the full filter time before it passes
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               cnt     <= 8'h00;
               filt[i] <= 1'b0;
            end
            else if (raw[i] == filt[i])
            begin
               cnt <= 8'h00;
            end
            else if (cnt == 8'(`DEGLITCH_CYC - 1))
            begin
               cnt     <= 8'h00;
               filt[i] <= raw[i];
            end
            else
            begin
               cnt <= cnt + 8'h01;
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// >>> rtl/gate_drv_ctrl.sv
// Gate driver protection and sense encoding logic with APB registers
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gate_drv_map.svh"

module gate_drv_ctrl
   import gate_drv_pkg::*;
#(
   parameter int FAULT_MUTE_CYC = `FAULT_MUTE_DEF,
   parameter int RST_FILTER_CYC = `RST_FILTER_DEF
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        pwm_noninv_in,
   input  wire logic        pwm_inv_in,
   input  wire logic        rst_en_in,
   input  wire logic        vcc_uvlo,
   input  wire logic        vdd_uvlo,
   input  wire logic        desaturation_sense_over_thresh,
   input  wire logic        gate_below_clamp,
   input  wire logic [12:0] analog_sense_mv,
   output var  logic        gate_pullup_out,
   output var  logic        gate_pulldown_out,
   output var  logic        gate_soft_off_out,
   output var  logic        miller_clamp_pin,
   output var  logic        desaturation_sense_discharge,
   output var  logic        desaturation_sense_charge_en,
   output var  logic        fault_alarm_n,
   output var  logic        fault_alarm_oe_n,
   output var  logic        supply_good,
   output var  logic        supply_good_oe_n,
   output var  logic        sensed_duty_out
);

   // ----------------------------------------------------------------
   // Input filtering
   // ----------------------------------------------------------------
   logic [2:0]  filt;
   logic        nin_f;
   logic        inv_f;
   logic        en_f;
   logic        en_prev;
   logic        uvlo;

   deglitch_bank u_deglitch
   (
      .pclk    (pclk),
      .presetn (presetn),
      .raw     ({rst_en_in, pwm_inv_in, pwm_noninv_in}),
      .filt    (filt)
   );

   assign nin_f = filt[0];
   assign inv_f = filt[1];
   assign en_f  = filt[2];
   assign uvlo  = vcc_uvlo | vdd_uvlo;

   // ----------------------------------------------------------------
   // Enable and reset filtering
   // ----------------------------------------------------------------
   logic [15:0] rst_low_cnt;
   logic        rst_long;
   logic        driver_enabled;

   assign rst_long = (rst_low_cnt == 16'(RST_FILTER_CYC));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rst_low_cnt <= 16'h0000;
      else if (en_f)
         rst_low_cnt <= 16'h0000;
      else if (!rst_long)
         rst_low_cnt <= rst_low_cnt + 16'h0001;
   end

   // Filter resets low, so a floating pin leaves the driver disabled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         driver_enabled <= 1'b0;
      else if (en_f)
         driver_enabled <= 1'b1;
      else if (rst_long)
         driver_enabled <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         en_prev <= 1'b0;
      else
         en_prev <= en_f;
   end

   // ----------------------------------------------------------------
   // Gate state machine
   // ----------------------------------------------------------------
   drv_state_t  state;
   drv_state_t  next_state;
   logic [7:0]  blank_cnt;
   logic [7:0]  next_blank;
   logic        armed;
   logic        fault_set;
   logic        fault_latched;
   logic        ctrl_allow;
   logic        pwm_request;

   // Interlock and lockout share one gate request term
   assign pwm_request = nin_f & ~inv_f & driver_enabled & ~uvlo
                        & ctrl_allow & ~fault_latched & ~rst_long;

   assign armed     = (blank_cnt == 8'(`BLANK_CYC));
   assign fault_set = (state == S_ON) & armed & desaturation_sense_over_thresh;

   always_comb
   begin
      next_state = state;
      next_blank = blank_cnt;
      unique case (state)
         S_OFF:
         begin
            next_blank = 8'h00;
            if (pwm_request)
               next_state = S_ON;
         end
         S_ON:
         begin
            if (fault_set)
               next_state = S_SOFT;
            else if (!pwm_request)
               next_state = S_OFF;
            if (!armed)
               next_blank = blank_cnt + 8'h01;
         end
         S_SOFT:
         begin
            next_blank = 8'h00;
            // Soft sink keeps pulling until the clamp can take over
            if (gate_below_clamp)
               next_state = S_OFF;
         end
         default:
         begin
            next_state = S_OFF;
            next_blank = 8'h00;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state     <= S_OFF;
         blank_cnt <= 8'h00;
      end
      else
      begin
         state     <= next_state;
         blank_cnt <= next_blank;
      end
   end

   // ----------------------------------------------------------------
   // Gate and desaturation outputs
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gate_pullup_out   <= 1'b0;
         gate_pulldown_out <= 1'b1;
         gate_soft_off_out <= 1'b0;
         miller_clamp_pin  <= 1'b0;
         desaturation_sense_discharge   <= 1'b1;
         desaturation_sense_charge_en   <= 1'b0;
      end
      else
      begin
         gate_pullup_out   <= (next_state == S_ON);
         gate_pulldown_out <= (next_state == S_OFF);
         gate_soft_off_out <= (next_state == S_SOFT);
         miller_clamp_pin  <= (next_state == S_OFF) & gate_below_clamp;
         desaturation_sense_discharge   <= (next_state != S_ON);
         desaturation_sense_charge_en   <= (next_state == S_ON)
                              & (next_blank == 8'(`BLANK_CYC));
      end
   end

   // ----------------------------------------------------------------
   // Fault latch, mute and clear
   // ----------------------------------------------------------------
   logic [15:0] mute_cnt;
   logic        mute_done;
   logic        clear_ready;
   logic        fault_clear;

   assign mute_done   = (mute_cnt == 16'(FAULT_MUTE_CYC));
   assign fault_clear = clear_ready & en_f & ~en_prev;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mute_cnt <= 16'h0000;
      else if (fault_set)
         mute_cnt <= 16'h0000;
      else if (fault_latched & !mute_done)
         mute_cnt <= mute_cnt + 16'h0001;
   end

   // Low time also counts during mute; ready once mute is over and the pin has been low long enough
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clear_ready <= 1'b0;
      else if (fault_set | fault_clear | !fault_latched)
         clear_ready <= 1'b0;
      else if (mute_done & rst_long)
         clear_ready <= 1'b1;
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fault_latched <= 1'b0;
      else if (fault_set)
         fault_latched <= 1'b1;
      else if (fault_clear)
         fault_latched <= 1'b0;
   end

   // Open-drain pins: data stays low, enable low pulls the line
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fault_alarm_n    <= 1'b0;
         fault_alarm_oe_n <= 1'b1;
         supply_good      <= 1'b0;
         supply_good_oe_n <= 1'b1;
      end
      else
      begin
         fault_alarm_n    <= 1'b0;
         fault_alarm_oe_n <= ~((fault_latched | fault_set) & ~fault_clear);
         supply_good      <= 1'b0;
         supply_good_oe_n <= ~uvlo;
      end
   end

   // ----------------------------------------------------------------
   // Sense duty encoder
   // ----------------------------------------------------------------
   logic [12:0] ain_clamped;
   logic [7:0]  duty_calc;
   logic [7:0]  duty_hi;
   logic [7:0]  period_cnt;
   logic        sense_run;

   // Floating input reads above the span and lands on minimum duty
   always_comb
   begin
      if (analog_sense_mv > 13'(`AIN_HI_MV))
         ain_clamped = 13'(`AIN_HI_MV);
      else if (analog_sense_mv < 13'(`AIN_LO_MV))
         ain_clamped = 13'(`AIN_LO_MV);
      else
         ain_clamped = analog_sense_mv;
      duty_calc = 8'(`DUTY_MIN_CYC)
                  + 8'((13'(`AIN_HI_MV) - ain_clamped) / 13'(`AIN_MV_PER_CYC));
   end

   assign sense_run = driver_enabled & ~uvlo;

   // Duty sampled once per period so a pulse never changes mid-cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         period_cnt <= 8'h00;
         duty_hi    <= 8'(`DUTY_MIN_CYC);
      end
      else if (!sense_run)
      begin
         period_cnt <= 8'h00;
      end
      else if (period_cnt == 8'(`SENSED_DUTY_OUT_PERIOD_CYC - 1))
      begin
         period_cnt <= 8'h00;
         duty_hi    <= duty_calc;
      end
      else
      begin
         period_cnt <= period_cnt + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sensed_duty_out <= 1'b0;
      else
         sensed_duty_out <= sense_run & (period_cnt < duty_hi);
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   status_t     status;
   logic [15:0] fault_count;
   logic [31:0] next_rdata;
   logic        next_err;
   logic        wr_en;

   assign status = '{clear_ready: clear_ready, enabled: driver_enabled,
                     uvlo: uvlo, soft_off: (state == S_SOFT),
                     gate_on: (state == S_ON), fault: fault_latched};
   assign wr_en  = psel & penable & pready & pwrite & ~pslverr;

   always_comb
   begin
      next_err   = 1'b0;
      next_rdata = `ERR_DATA;
      unique case (paddr)
         `REG_STATUS:  next_rdata = 32'(status);
         `REG_CONTROL: next_rdata = 32'(ctrl_allow);
         `REG_SENSE:   next_rdata = 32'(duty_hi);
         `REG_FAULTS:  next_rdata = 32'(fault_count);
         default:      next_err   = 1'b1;
      endcase
   end

   // One wait-free access: answer is ready in the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `ERR_DATA;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & next_err;
         prdata  <= (psel & ~penable & ~pwrite) ? next_rdata : `ERR_DATA;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_allow <= `CTRL_ALLOW_RST;
      else if (wr_en & (paddr == `REG_CONTROL))
         ctrl_allow <= pwdata[0];
   end

   // Counter write clears; a fault in the same cycle still counts
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fault_count <= 16'h0000;
      else if (fault_set)
         fault_count <= (wr_en & (paddr == `REG_FAULTS)) ? 16'h0001
                        : fault_count + 16'h0001;
      else if (wr_en & (paddr == `REG_FAULTS))
         fault_count <= 16'h0000;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_shoot_through_low: assert property ((nin_f & inv_f) |=> !gate_pullup_out)
      else $error("gate high with both inputs high");
   a_uvlo_gate_low: assert property (uvlo |=> !gate_pullup_out)
      else $error("gate high during lockout");
   a_uvlo_pins_low: assert property (uvlo |=> !supply_good_oe_n && !sensed_duty_out)
      else $error("supply good or duty not low in lockout");
   a_blank_no_charge: assert property ($rose(gate_pullup_out) |-> !desaturation_sense_charge_en[*8])
      else $error("charge started inside blanking");
   a_off_no_charge: assert property (!gate_pullup_out |-> !desaturation_sense_charge_en)
      else $error("desaturation_sense charge while gate off");
   a_low_discharge: assert property (gate_pulldown_out |-> desaturation_sense_discharge)
      else $error("desaturation_sense not discharged while gate low");
   a_fault_soft_off: assert property (fault_set |=> gate_soft_off_out && !gate_pulldown_out)
      else $error("fault without soft turn off");
   a_fault_alarm_held: assert property (fault_set |=> !fault_alarm_oe_n[*8])
      else $error("alarm not held after fault");
   a_disable_on_low: assert property (rst_long && !en_f |=> !driver_enabled && !gate_pullup_out)
      else $error("driver still enabled after long low");
   a_clear_on_rise: assert property (fault_clear |=> !fault_latched ##1 fault_alarm_oe_n)
      else $error("alarm not released after clear");
   a_clamp_when_low: assert property ((next_state == S_OFF) && gate_below_clamp
                                      |=> miller_clamp_pin)
      else $error("clamp not engaged below threshold");

   c_fault_seen:   cover property (fault_set);
   c_fault_clear:  cover property (fault_clear);
   c_gate_on:      cover property ($rose(gate_pullup_out));
   c_charge_armed: cover property ($rose(desaturation_sense_charge_en));

endmodule
`default_nettype wire

// >>> verif/gate_host_model.sv
// Host side model driving the PWM and reset/enable pins, with pull-ups on open-drain lines
`timescale 1ns/1ps
`default_nettype none

module gate_host_model
#(
   parameter int HOLD_CYC = 24
)
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic cmd_nin,
   input  wire logic cmd_inv,
   input  wire logic cmd_rst,
   input  wire logic clear_req,
   input  wire logic alarm_oe_n,
   input  wire logic ready_oe_n,
   output var  logic pwm_noninv_in,
   output var  logic pwm_inv_in,
   output var  logic rst_en_in,
   output var  logic alarm_line,
   output var  logic ready_line
);
   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   int clr_cnt;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwm_noninv_in <= 1'b0;
         pwm_inv_in    <= 1'b0;
         rst_en_in     <= 1'b0;
         clr_cnt       <= 0;
      end
      else
      begin
         pwm_noninv_in <= cmd_nin;
         pwm_inv_in    <= cmd_inv;
         if (clear_req)
            clr_cnt <= HOLD_CYC;
         else if (clr_cnt != 0)
            clr_cnt <= clr_cnt - 1;
         // Clear pulse is long enough to outlast the filter after mute
         rst_en_in <= cmd_rst && (clr_cnt == 0) && !clear_req;
      end
   end

   // ----------------------------------------------------------------
   // Open-drain lines with external pull-up
   // ----------------------------------------------------------------
   assign alarm_line = alarm_oe_n ? 1'b1 : 1'b0;
   assign ready_line = ready_oe_n ? 1'b1 : 1'b0;
endmodule
`default_nettype wire

// >>> verif/isolated_gate_driver_protection_logic_tb.sv
// Self-checking bench for the gate driver protection logic
`timescale 1ns/1ps
`default_nettype none

module isolated_gate_driver_protection_logic_tb;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata;
   logic        pready, pslverr;
   logic        pwm_noninv_in, pwm_inv_in, rst_en_in;
   logic        cmd_nin = 1'b0, cmd_inv = 1'b0, cmd_rst = 1'b0, clear_req = 1'b0;
   logic        vcc_uvlo = 1'b0, vdd_uvlo = 1'b0;
   logic        desaturation_sense_over_thresh = 1'b0, gate_below_clamp = 1'b0;
   logic [12:0] analog_sense_mv = 13'h1388;
   logic        gate_pullup_out, gate_pulldown_out, gate_soft_off_out;
   logic        miller_clamp_pin, desaturation_sense_discharge, desaturation_sense_charge_en;
   logic        fault_alarm_n, fault_alarm_oe_n, supply_good, supply_good_oe_n;
   logic        sensed_duty_out, alarm_line, ready_line;
   logic [31:0] rd;
   logic        err;
   int          error_cnt = 0, cmp_count = 0, n, hi;
   int          mv_tab[3] = '{600, 2500, 5000};
   int          hi_tab[3] = '{220, 125, 25};

   always #5 pclk = ~pclk;

   gate_drv_ctrl #(.FAULT_MUTE_CYC(40), .RST_FILTER_CYC(10)) dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pwm_noninv_in(pwm_noninv_in), .pwm_inv_in(pwm_inv_in), .rst_en_in(rst_en_in),
      .vcc_uvlo(vcc_uvlo), .vdd_uvlo(vdd_uvlo), .desaturation_sense_over_thresh(desaturation_sense_over_thresh),
      .gate_below_clamp(gate_below_clamp), .analog_sense_mv(analog_sense_mv),
      .gate_pullup_out(gate_pullup_out), .gate_pulldown_out(gate_pulldown_out),
      .gate_soft_off_out(gate_soft_off_out), .miller_clamp_pin(miller_clamp_pin),
      .desaturation_sense_discharge(desaturation_sense_discharge), .desaturation_sense_charge_en(desaturation_sense_charge_en),
      .fault_alarm_n(fault_alarm_n), .fault_alarm_oe_n(fault_alarm_oe_n),
      .supply_good(supply_good), .supply_good_oe_n(supply_good_oe_n),
      .sensed_duty_out(sensed_duty_out)
   );

   gate_host_model #(.HOLD_CYC(24)) hm
   (
      .pclk(pclk), .presetn(presetn), .cmd_nin(cmd_nin), .cmd_inv(cmd_inv),
      .cmd_rst(cmd_rst), .clear_req(clear_req), .alarm_oe_n(fault_alarm_oe_n),
      .ready_oe_n(supply_good_oe_n), .pwm_noninv_in(pwm_noninv_in),
      .pwm_inv_in(pwm_inv_in), .rst_en_in(rst_en_in), .alarm_line(alarm_line),
      .ready_line(ready_line)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (error_cnt == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic sig(input int s);
      case (s)
         0: sig = gate_pullup_out;
         1: sig = desaturation_sense_charge_en;
         2: sig = sensed_duty_out;
         3: sig = gate_pulldown_out;
         4: sig = alarm_line;
         default: sig = ready_line;
      endcase
   endfunction

   // Bounded wait; counts edges until the level is seen
   task automatic wt(input int s, input logic v, output int cnt);
      cnt = 0;
      while (sig(s) !== v && cnt < 2000)
      begin
         @(posedge pclk);
         #1;
         cnt++;
      end
      if (cnt >= 2000)
      begin
         error_cnt++;
         stop_test();
      end
   endtask

   // APB transfer held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         error_cnt++;
         stop_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      chk(gate_pulldown_out, 1'b1);
      chk(desaturation_sense_discharge, 1'b1);
      chk({fault_alarm_n, supply_good}, 2'b00);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h00000001);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd[4:0], 5'h00);
      apb(1'b1, 12'h010, 32'h0000FFFF);
      chk(rd, 32'h00000000);
      chk(err, 1'b1);
      chk(ready_line, 1'b1);
      // Turn on, blanking delay and interlock
      @(posedge pclk);
      cmd_rst <= 1'b1;
      cmd_nin <= 1'b1;
      wt(0, 1'b1, n);
      chk(desaturation_sense_discharge, 1'b0);
      wt(1, 1'b1, n);
      chk(n, 20);
      @(posedge pclk);
      cmd_inv <= 1'b1;
      wt(0, 1'b0, n);
      chk(desaturation_sense_charge_en, 1'b0);
      @(posedge pclk);
      cmd_inv <= 1'b0;
      wt(0, 1'b1, n);
      @(posedge pclk);
      cmd_inv <= 1'b1;
      @(posedge pclk);
      @(posedge pclk);
      cmd_inv <= 1'b0;
      repeat (10)
      begin
         @(posedge pclk);
         #1;
         chk(gate_pullup_out, 1'b1);
      end
      // Desaturation fault, soft turn-off, clamp, mute and clear
      wt(1, 1'b1, n);
      @(posedge pclk);
      desaturation_sense_over_thresh <= 1'b1;
      @(posedge pclk);
      #1;
      chk({gate_soft_off_out, gate_pullup_out, alarm_line}, 3'b100);
      @(posedge pclk);
      desaturation_sense_over_thresh <= 1'b0;
      cmd_rst <= 1'b0;
      gate_below_clamp <= 1'b1;
      wt(3, 1'b1, n);
      chk(miller_clamp_pin, 1'b1);
      repeat (18) @(posedge pclk);
      cmd_rst <= 1'b1;
      gate_below_clamp <= 1'b0;
      repeat (10) @(posedge pclk);
      #1;
      chk(alarm_line, 1'b0);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, 32'h00000001);
      @(posedge pclk);
      clear_req <= 1'b1;
      @(posedge pclk);
      clear_req <= 1'b0;
      wt(4, 1'b1, n);
      chk(n >= 24, 1'b1);
      wt(0, 1'b1, n);
      apb(1'b1, 12'h00C, 32'h0);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, 32'h00000000);
      // Disable through the pin, no detection while off
      @(posedge pclk);
      cmd_rst <= 1'b0;
      wt(0, 1'b0, n);
      chk(gate_pulldown_out, 1'b1);
      // Comparator only raised once the gate is off, else blanking ends first
      @(posedge pclk);
      desaturation_sense_over_thresh <= 1'b1;
      repeat (5) @(posedge pclk);
      #1;
      chk({alarm_line, gate_soft_off_out}, 2'b10);
      @(posedge pclk);
      desaturation_sense_over_thresh <= 1'b0;
      cmd_rst <= 1'b1;
      wt(0, 1'b1, n);
      // Register gate-off control
      apb(1'b1, 12'h004, 32'h00000000);
      wt(0, 1'b0, n);
      apb(1'b1, 12'h004, 32'h00000001);
      wt(0, 1'b1, n);
      // Lockout on either supply
      @(posedge pclk);
      vdd_uvlo <= 1'b1;
      wt(0, 1'b0, n);
      wt(5, 1'b0, n);
      repeat (300) @(posedge pclk);
      #1;
      chk(sensed_duty_out, 1'b0);
      @(posedge pclk);
      vdd_uvlo <= 1'b0;
      vcc_uvlo <= 1'b1;
      repeat (8) @(posedge pclk);
      #1;
      chk({gate_pullup_out, ready_line}, 2'b00);
      @(posedge pclk);
      vcc_uvlo <= 1'b0;
      // Duty encoding, second period after each change
      for (int i = 0; i < 3; i++)
      begin
         @(posedge pclk);
         analog_sense_mv <= 13'(mv_tab[i]);
         repeat (2)
         begin
            wt(2, 1'b0, n);
            wt(2, 1'b1, n);
            wt(2, 1'b0, hi);
         end
         wt(2, 1'b1, n);
         chk(hi, hi_tab[i]);
         chk(hi + n, 250);
         apb(1'b0, 12'h008, 32'h0);
         chk(rd, hi_tab[i]);
      end
      stop_test();
   end
endmodule
`default_nettype wire
